// ---- src/mcu_reset_source_controller.sv ----
// Purpose: Combines reset sources, keeps cause flags, sequences the release
// Assumes: wdt_timeout, halt_pulse, clr_wdt_pulse are pclk pulses from the core
// Notes:   presetn is the power-on reset; registers reached over APB
`timescale 1ns/10ps
`include "rstc_consts.svh"

// How it works
// - Low-voltage reset only when enabled, threshold configurable
// - Qualified low supply raises internal reset
// - Short low-supply dips are ignored
// - Running watchdog time-out resets, sets time-out flag
// - Watchdog reset waits the power-on delay
// - Sleep time-out clears only PC, SP; sets flag
// - RC clocks may select two-cycle start-up
// - Crystal clocks count 128 start-up cycles
// - Flags readable, updated by sleep and watchdog
// - Flag values per reset cause
// - Pin or low-voltage reset keeps flags
// - Power-on reset disables all interrupts
// - Watchdog cleared in reset, counts after
// - Power-on turns timer off
// - Power-on presets ports to all ones
// - Power-on points stack to top
// - Pin reset returns program counter to zero
// - Sleep watchdog time-out wakes the device
module mcu_reset_source_controller
  import rstc_pkg::*;
#(
  parameter int POWER_ON_DELAY_CYCLES = `RSTC_POWER_ON_DELAY_CYCLES,
  parameter int LV_MIN_CYCLES         = `RSTC_LV_MIN_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_reset_pin_n,
  input  wire logic        supply_low,
  input  wire logic        wdt_timeout,
  input  wire logic        core_sleeping,
  input  wire logic        halt_pulse,
  input  wire logic        clr_wdt_pulse,
  output logic [1:0]       low_voltage_threshold,
  output logic             core_reset_n,
  output logic             pc_clear,
  output logic             sp_clear,
  output logic             wake_req,
  output logic             wdt_clear,
  output logic             intr_disable,
  output logic             timer_off,
  output logic             port_preset,
  output logic [7:0]       port_preset_value,
  output logic             stack_top_set,
  output logic             watchdog_timeout_flag,
  output logic             powerdown_flag
);
  rstc_if lnk ();

  seq_state_t  state;
  seq_state_t  next_state;
  cause_t      cause;
  logic [4:0]  config_reg;
  logic        pin_meta;
  logic        pin_sync_n;
  logic        low_meta;
  logic        low_sync;
  logic        source_active;
  logic        wdt_run;
  logic        wdt_sleep;
  logic        apb_write;
  logic        apb_read;
  logic        next_held;

  // Register decode used only for the pslverr response on unmapped addresses
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == `RSTC_CONFIG_OFFS) || (addr == `RSTC_STATUS_OFFS);
  endfunction

  // Two-flop synchronisers for the pin and the supply monitor
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta   <= 1'b1;
      pin_sync_n <= 1'b1;
      low_meta   <= 1'b0;
      low_sync   <= 1'b0;
    end
    else
    begin
      pin_meta   <= external_reset_pin_n;
      pin_sync_n <= pin_meta;
      low_meta   <= supply_low;
      low_sync   <= low_meta;
    end
  end

  // Supply filter and start-up timer
  assign lnk.lv_enable = config_reg[`RSTC_CFG_LV_EN_BIT];
  assign lnk.lv_low    = low_sync;

  lv_filter #(.MIN_CYCLES(LV_MIN_CYCLES)) u_filter
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk.filt)
  );

  startup_timer #(.DELAY_CYCLES(POWER_ON_DELAY_CYCLES)) u_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk.tmr)
  );

  // Pin and low-voltage reset outrank a watchdog time-out
  assign source_active = !pin_sync_n || lnk.lv_reset;
  assign wdt_run       = wdt_timeout && !core_sleeping && !source_active;
  assign wdt_sleep     = wdt_timeout && core_sleeping && !source_active;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (source_active || wdt_run)
          next_state = ST_HOLD;
        else if (wdt_sleep)
          next_state = ST_WAKE;
      end
      ST_HOLD:
      begin
        if (!source_active)
          next_state = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (source_active)
          next_state = ST_HOLD;
        else if (lnk.tmr_done && !lnk.tmr_start) // Stale done from a cut count is ignored
          next_state = ST_RUN;
      end
      ST_WAKE:
      begin
        if (source_active)
          next_state = ST_HOLD;
        else if (lnk.tmr_done)
          next_state = ST_RUN;
      end
      default: next_state = ST_HOLD;
    endcase
  end

  // State starts in hold so power-on runs the full delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_HOLD;
    else
      state <= next_state;
  end

  // Timer kick: delay for resets, start-up count only for sleep wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lnk.tmr_start      <= 1'b0;
      lnk.tmr_with_delay <= 1'b0;
      lnk.tmr_long       <= 1'b1;
    end
    else
    begin
      lnk.tmr_start      <= (state != ST_DELAY && next_state == ST_DELAY) ||
                            (state == ST_RUN && next_state == ST_WAKE);
      lnk.tmr_with_delay <= next_state == ST_DELAY;
      lnk.tmr_long       <= config_reg[`RSTC_CFG_CRYSTAL_BIT] ||
                            !config_reg[`RSTC_CFG_SHORT_BIT];
    end
  end

  // Remember the cause of the latest reset or wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause <= CAUSE_POWER_ON;
    else if (state == ST_RUN && !pin_sync_n)
      cause <= CAUSE_PIN;
    else if (state == ST_RUN && lnk.lv_reset)
      cause <= CAUSE_LOW_VOLT;
    else if (state == ST_RUN && wdt_run)
      cause <= CAUSE_WDT_RUN;
    else if (state == ST_RUN && wdt_sleep)
      cause <= CAUSE_WDT_SLP;
  end

  // Cause flags; a setting event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
    end
    else if (state == ST_RUN && (wdt_run || wdt_sleep))
    begin
      watchdog_timeout_flag <= 1'b1;
      powerdown_flag        <= wdt_sleep ? 1'b1 : powerdown_flag;
    end
    else if (state == ST_RUN && halt_pulse)
    begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b1;
    end
    else if (state == ST_RUN && clr_wdt_pulse)
    begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
    end
  end

  // Core and peripheral initialisation levels, held while in reset
  assign next_held = next_state == ST_HOLD || next_state == ST_DELAY;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset_n      <= 1'b0;
      intr_disable      <= 1'b1;
      timer_off         <= 1'b1;
      port_preset       <= 1'b1;
      port_preset_value <= `RSTC_PORT_RESET_VALUE;
      stack_top_set     <= 1'b1;
      wdt_clear         <= 1'b1;
    end
    else
    begin
      core_reset_n      <= !next_held;
      intr_disable      <= next_held;
      timer_off         <= next_held;
      port_preset       <= next_held;
      port_preset_value <= `RSTC_PORT_RESET_VALUE;
      stack_top_set     <= next_held;
      wdt_clear         <= next_held;
    end
  end

  // Program counter and stack pointer clears; wake on start-up end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_clear <= 1'b1;
      sp_clear <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      pc_clear <= next_held || (state == ST_RUN && next_state == ST_WAKE);
      sp_clear <= state == ST_RUN && next_state == ST_WAKE;
      wake_req <= state == ST_WAKE && next_state == ST_RUN;
    end
  end

  // APB slave: answer one cycle into the access phase
  assign apb_write = psel && penable && !pready && pwrite;
  assign apb_read  = psel && penable && !pready && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
      if (apb_read && paddr == `RSTC_CONFIG_OFFS)
        prdata <= {27'h0, config_reg};
      else if (apb_read && paddr == `RSTC_STATUS_OFFS)
        prdata <= {26'h0, state != ST_RUN, cause,
                   powerdown_flag, watchdog_timeout_flag};
      else
        prdata <= 32'h00000000;
    end
  end

  // Configuration options survive every reset but power-on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_reg <= `RSTC_CONFIG_RESET;
    else if (apb_write && paddr == `RSTC_CONFIG_OFFS)
      config_reg <= pwdata[4:0];
  end

  // Threshold selection drives the supply monitor
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_voltage_threshold <= 2'h0;
    else
      low_voltage_threshold <= config_reg[`RSTC_CFG_THR_MSB:`RSTC_CFG_THR_LSB];
  end

  // Checks
  sequence run_wdt_s;
    state == ST_RUN && wdt_timeout && !core_sleeping && !source_active;
  endsequence

  sequence sleep_wdt_s;
    state == ST_RUN && wdt_timeout && core_sleeping && !source_active;
  endsequence

  lv_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    !config_reg[`RSTC_CFG_LV_EN_BIT] |=> !lnk.lv_reset)
    else $error("low-voltage reset while disabled");

  wdt_sets_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_wdt_s |=> watchdog_timeout_flag && !core_reset_n)
    else $error("running time-out did not reset and flag");

  sleep_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_wdt_s |=> watchdog_timeout_flag && powerdown_flag && pc_clear && sp_clear
                    && core_reset_n && !intr_disable)
    else $error("sleep time-out flags or clears wrong");

  pin_keeps_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_HOLD |=> $stable(watchdog_timeout_flag) && $stable(powerdown_flag))
    else $error("flags changed during pin or low-voltage reset");

  hold_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_DELAY |-> !core_reset_n && intr_disable && timer_off && port_preset
                          && stack_top_set && wdt_clear && port_preset_value == 8'hFF)
    else $error("initial conditions not held in reset");

  release_on_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n) |-> $past(lnk.tmr_done) && $past(state) == ST_DELAY)
    else $error("core released before start-up count ended");

  wake_after_sst_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_wdt_s ##1 (!source_active)[*4] |-> ##[0:200] wake_req)
    else $error("sleep time-out did not wake the core");

  short_sst_a: assert property (@(posedge pclk) disable iff (!presetn)
    lnk.tmr_start && !lnk.tmr_with_delay && !lnk.tmr_long |-> ##3 lnk.tmr_done)
    else $error("short start-up count is not two cycles");

  wdt_clear_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n) |-> !wdt_clear)
    else $error("watchdog still cleared after release");
endmodule

// ---- src/rstc_consts.svh ----
// Purpose: Offsets, fields, reset values and timing counts of the reset controller
// Assumes: pclk at 125 MHz
// Notes:   Definitions only
`ifndef RSTC_CONSTS_SVH
`define RSTC_CONSTS_SVH

// Register byte offsets
`define RSTC_CONFIG_OFFS      12'h000
`define RSTC_STATUS_OFFS      12'h004

// Config fields
`define RSTC_CFG_LV_EN_BIT    0
`define RSTC_CFG_THR_LSB      1
`define RSTC_CFG_THR_MSB      2
`define RSTC_CFG_CRYSTAL_BIT  3
`define RSTC_CFG_SHORT_BIT    4
`define RSTC_CONFIG_RESET     5'h01

// Status fields
`define RSTC_ST_TIMEOUT_BIT   0
`define RSTC_ST_PDOWN_BIT     1
`define RSTC_ST_CAUSE_LSB     2
`define RSTC_ST_HELD_BIT      5

// Port preset value after reset: all inputs, latches high
`define RSTC_PORT_RESET_VALUE 8'hFF

// Timing
`define RSTC_CLK_PERIOD_NS    8
`define RSTC_POWER_ON_DELAY_MS 50
`define RSTC_POWER_ON_DELAY_CYCLES ((`RSTC_POWER_ON_DELAY_MS * 1000000) / `RSTC_CLK_PERIOD_NS)
`define RSTC_LV_MIN_DURATION_NS 120000
`define RSTC_LV_MIN_CYCLES \
  ((`RSTC_LV_MIN_DURATION_NS + `RSTC_CLK_PERIOD_NS - 1) / `RSTC_CLK_PERIOD_NS)
`define RSTC_SST_SHORT_CYCLES 8'h02
`define RSTC_SST_LONG_CYCLES  8'h80

`endif

// ---- src/rstc_pkg.sv ----
// Purpose: Types shared by the reset controller modules
// Assumes: Nothing
// Notes:   Sequencer states Gray coded along hold, delay, run
package rstc_pkg;
  typedef enum logic [2:0]
  {
    ST_HOLD  = 3'h1,
    ST_DELAY = 3'h3,
    ST_RUN   = 3'h2,
    ST_WAKE  = 3'h6
  } seq_state_t;

  typedef enum logic [2:0]
  {
    CAUSE_POWER_ON = 3'h0,
    CAUSE_PIN      = 3'h1,
    CAUSE_LOW_VOLT = 3'h2,
    CAUSE_WDT_RUN  = 3'h3,
    CAUSE_WDT_SLP  = 3'h4
  } cause_t;
endpackage

// ---- src/rstc_if.sv ----
// Purpose: Links sequencer, start-up timer and supply filter
// Assumes: One clock domain
// Notes:   Plain carrier, no logic
`timescale 1ns/10ps
interface rstc_if;
  logic tmr_start;
  logic tmr_with_delay;
  logic tmr_long;
  logic tmr_done;
  logic lv_enable;
  logic lv_low;
  logic lv_reset;

  modport seq  (output tmr_start, output tmr_with_delay, output tmr_long, input tmr_done,
                output lv_enable, output lv_low, input lv_reset);
  modport tmr  (input tmr_start, input tmr_with_delay, input tmr_long, output tmr_done);
  modport filt (input lv_enable, input lv_low, output lv_reset);
endinterface

// ---- src/lv_filter.sv ----
// Purpose: Qualifies a low-supply level by its duration
// Assumes: lv_low already synchronised to pclk
// Notes:   Short dips are dropped without effect
`timescale 1ns/10ps
`include "rstc_consts.svh"
module lv_filter
#(
  parameter int MIN_CYCLES = `RSTC_LV_MIN_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  rstc_if.filt      lnk
);
  logic [23:0] low_count;

  // Count while low; only a dip longer than the minimum fires
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_count    <= 24'h000000;
      lnk.lv_reset <= 1'b0;
    end
    else if (!lnk.lv_enable || !lnk.lv_low)
    begin
      low_count    <= 24'h000000;
      lnk.lv_reset <= 1'b0;
    end
    else if (low_count >= MIN_CYCLES[23:0])
      lnk.lv_reset <= 1'b1;
    else
      low_count <= low_count + 24'h000001;
  end

  lv_short_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(lnk.lv_reset) |-> $past(lnk.lv_low) && low_count >= MIN_CYCLES[23:0])
    else $error("low-voltage reset without a qualified dip");
endmodule

// ---- src/startup_timer.sv ----
// Purpose: Power-on delay followed by the system start-up count
// Assumes: start is a one-cycle pulse, not repeated while busy
// Notes:   done is a one-cycle pulse
`timescale 1ns/10ps
`include "rstc_consts.svh"
module startup_timer
#(
  parameter int DELAY_CYCLES = `RSTC_POWER_ON_DELAY_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  rstc_if.tmr       lnk
);
  logic [22:0] delay_left;
  logic [7:0]  sst_left;
  logic        busy;

  // Delay phase first, then the oscillator start-up count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      delay_left   <= 23'h0;
      sst_left     <= 8'h00;
      busy         <= 1'b0;
      lnk.tmr_done <= 1'b0;
    end
    else if (lnk.tmr_start)
    begin
      delay_left   <= lnk.tmr_with_delay ? DELAY_CYCLES[22:0] : 23'h0;
      sst_left     <= lnk.tmr_long ? `RSTC_SST_LONG_CYCLES : `RSTC_SST_SHORT_CYCLES;
      busy         <= 1'b1;
      lnk.tmr_done <= 1'b0;
    end
    else if (busy && delay_left != 23'h0)
    begin
      delay_left   <= delay_left - 23'h1;
      lnk.tmr_done <= 1'b0;
    end
    else if (busy)
    begin
      sst_left     <= sst_left - 8'h01;
      busy         <= sst_left != 8'h01;
      lnk.tmr_done <= sst_left == 8'h01;
    end
    else
      lnk.tmr_done <= 1'b0;
  end
endmodule

// ---- bench/core_partner.sv ----
// Purpose: Core, watchdog and supply side as seen by the reset controller
// Assumes: Bench requests arrive as one-cycle levels on go
// Notes:   Sleep ends on a wake pulse or on any core reset
`timescale 1ns/10ps
module core_partner
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_reset_n,
  input  wire logic       wake_req,
  input  wire logic [2:0] go,
  output logic            wdt_timeout,
  output logic            halt_pulse,
  output logic            clr_wdt_pulse,
  output logic            core_sleeping
);
  // Watchdog fires even while the core is held, so the controller must drop it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_timeout   <= 1'b0;
      halt_pulse    <= 1'b0;
      clr_wdt_pulse <= 1'b0;
    end
    else
    begin
      wdt_timeout   <= go[0];
      halt_pulse    <= go[1] & core_reset_n & ~core_sleeping;
      clr_wdt_pulse <= go[2] & core_reset_n & ~core_sleeping;
    end
  end

  // Sleep level; a halted core leaves it only by wake or reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_sleeping <= 1'b0;
    else if (!core_reset_n || wake_req)
      core_sleeping <= 1'b0;
    else if (halt_pulse)
      core_sleeping <= 1'b1;
  end
endmodule

// ---- bench/tb_mcu_reset_source_controller.sv ----
// Purpose: Self-checking bench for the reset source controller
// Assumes: Shortened power-on delay and low-supply filter counts
// Notes:   Release windows allow a few cycles of sync slack
`timescale 1ns/10ps
`include "rstc_consts.svh"
module tb_mcu_reset_source_controller;
  localparam int DLY = 20;
  localparam int LVM = 10;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, seed = 32'hD36D6184;
  logic        pready, pslverr, e, pin_n = 1, supply_low = 0;
  logic [2:0]  go = 0;
  logic        wdt_timeout, core_sleeping, halt_pulse, clr_wdt_pulse;
  logic [1:0]  thr;
  logic        core_reset_n, pc_clear, sp_clear, wake_req, wdt_clear, intr_disable;
  logic        timer_off, port_preset, stack_top_set, to_f, pd_f;
  logic [7:0]  ppv;
  int          err_count = 0, samples_checked = 0, low_n = 0, sp_n = 0, wk_n = 0;

  mcu_reset_source_controller #(.POWER_ON_DELAY_CYCLES(DLY), .LV_MIN_CYCLES(LVM)) DUT
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .external_reset_pin_n(pin_n), .supply_low(supply_low), .wdt_timeout(wdt_timeout),
   .core_sleeping(core_sleeping), .halt_pulse(halt_pulse), .clr_wdt_pulse(clr_wdt_pulse),
   .low_voltage_threshold(thr), .core_reset_n(core_reset_n), .pc_clear(pc_clear),
   .sp_clear(sp_clear), .wake_req(wake_req), .wdt_clear(wdt_clear),
   .intr_disable(intr_disable), .timer_off(timer_off), .port_preset(port_preset),
   .port_preset_value(ppv), .stack_top_set(stack_top_set),
   .watchdog_timeout_flag(to_f), .powerdown_flag(pd_f));

  core_partner partner
  (.pclk(pclk), .presetn(presetn), .core_reset_n(core_reset_n), .wake_req(wake_req),
   .go(go), .wdt_timeout(wdt_timeout), .halt_pulse(halt_pulse),
   .clr_wdt_pulse(clr_wdt_pulse), .core_sleeping(core_sleeping));

  always #4 pclk = ~pclk;

  // Count held cycles and one-cycle pulses as the design presents them
  always @(posedge pclk)
  begin
    if (core_reset_n === 1'b0) low_n++;
    if (sp_clear === 1'b1) sp_n++;
    if (wake_req === 1'b1) wk_n++;
  end

  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask

  task rng(input string n, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      err_count++;
    end
  endtask

  // One APB transfer; the request stands until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    chk("apb_ready", 1, pready);
  endtask

  task ev(input int k);
    @(posedge pclk);
    go <= 3'(1 << k);
    @(posedge pclk);
    go <= 3'h0;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task cfg(input logic [4:0] c);
    seed = lfsr(seed);
    apb(1, `RSTC_CONFIG_OFFS, {seed[31:5], c});
    apb(0, `RSTC_CONFIG_OFFS, 0);
    chk("config", c, q[4:0]);
    chk("threshold", c[2:1], thr);
  endtask

  task flags(input logic [1:0] f);
    apb(0, `RSTC_STATUS_OFFS, 0);
    chk("status_flags", f, q[1:0]);
    chk("flag_pins", f, {pd_f, to_f});
  endtask

  task held();
    chk("core_held", 0, core_reset_n);
    chk("init_outputs", {6'h3F, 8'hFF}, {wdt_clear, intr_disable, timer_off, port_preset,
        stack_top_set, pc_clear, ppv});
  endtask

  // Waits for release, then checks the held span and the init outputs
  task run_wait(input int lo, input int hi);
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    #1;
    rng("release_cycles", lo, hi, low_n);
    chk("init_released", 0, {wdt_clear, intr_disable, timer_off, port_preset,
        stack_top_set, pc_clear});
  endtask

  task results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run is about a thousand cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results();
  end

  initial
  begin
    int len;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    #1;
    held();
    low_n = 0;
    run_wait(DLY, DLY + 200);
    apb(0, `RSTC_CONFIG_OFFS, 0);
    chk("config_reset", `RSTC_CONFIG_RESET, q[4:0]);
    apb(0, `RSTC_STATUS_OFFS, 0);
    chk("status_reset", 0, q[5:0]);
    apb(1, `RSTC_STATUS_OFFS, 32'hFFFFFFFF);
    flags(2'b00);
    apb(0, 12'h008, 0);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, q);
    $display("test power_on done");
    seed = lfsr(seed);
    cfg({2'b01, seed[1:0], 1'b1});
    low_n = 0;
    ev(0);
    held();
    run_wait(DLY + 128, DLY + 128 + 8);
    flags(2'b01);
    chk("cause", rstc_pkg::CAUSE_WDT_RUN, q[4:2]);
    $display("test watchdog_run done");
    cfg({2'b10, seed[3:2], 1'b1});
    ev(1);
    flags(2'b10);
    chk("sleeping", 1, core_sleeping);
    low_n = 0; sp_n = 0; wk_n = 0;
    ev(0);
    len = 0;
    while (wk_n == 0 && len < 300)
    begin
      @(posedge pclk);
      len++;
    end
    #1;
    chk("sp_clear_pulses", 1, sp_n);
    chk("wake_pulses", 1, wk_n);
    chk("no_core_reset", 0, low_n);
    flags(2'b11);
    chk("cause", rstc_pkg::CAUSE_WDT_SLP, q[4:2]);
    $display("test watchdog_sleep done");
    low_n = 0;
    ev(0);
    run_wait(DLY + 2, DLY + 2 + 8);
    flags(2'b11);
    $display("test watchdog_short done");
    low_n = 0;
    @(posedge pclk);
    pin_n <= 0;
    repeat (6) @(posedge pclk);
    #1;
    held();
    ev(0);
    @(posedge pclk);
    pin_n <= 1;
    run_wait(DLY + 2, DLY + 2 + 40);
    flags(2'b11);
    chk("cause", rstc_pkg::CAUSE_PIN, q[4:2]);
    $display("test pin done");
    seed = lfsr(seed);
    len = 2 + int'(seed[2:0]);
    low_n = 0;
    supply_low <= 1;
    repeat (len) @(posedge pclk);
    supply_low <= 0;
    repeat (10) @(posedge pclk);
    chk("short_dip", 0, low_n);
    cfg({2'b10, seed[4:3], 1'b0});
    supply_low <= 1;
    repeat (3 * LVM) @(posedge pclk);
    supply_low <= 0;
    repeat (10) @(posedge pclk);
    chk("lv_disabled", 0, low_n);
    cfg({2'b10, seed[6:5], 1'b1});
    supply_low <= 1;
    repeat (LVM + 10) @(posedge pclk);
    #1;
    held();
    @(posedge pclk);
    supply_low <= 0;
    run_wait(DLY + 2, DLY + 2 + 60);
    flags(2'b11);
    chk("cause", rstc_pkg::CAUSE_LOW_VOLT, q[4:2]);
    $display("test low_voltage done");
    ev(2);
    flags(2'b00);
    ev(1);
    flags(2'b10);
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    #1;
    chk("flags_power_on", 0, {pd_f, to_f});
    held();
    @(posedge pclk);
    presetn <= 1;
    low_n = 0;
    run_wait(DLY, DLY + 200);
    flags(2'b00);
    $display("test second_power_on done");
    results();
  end
endmodule
